/* rtl/eeprom_cmd_pkg.sv */
package eeprom_cmd_pkg;

  typedef enum logic [2:0]
  {
    st_hunt,
    st_cmd,
    st_data,
    st_read,
    st_done
  } seq_state_t;

  typedef enum logic [2:0]
  {
    op_none,
    op_write,
    op_program_all,
    op_erase,
    op_clear_all
  } prog_op_t;

endpackage

/* rtl/eeprom_cmd_regs.svh */
`ifndef EEPROM_CMD_REGS_SVH
`define EEPROM_CMD_REGS_SVH

`define EE_ADDR_W 6
`define EE_DATA_W 16
`define EE_DEPTH 64
`define EE_CMD_BITS 8
`define EE_CMD_LAST 3'h7
`define EE_DATA_LAST 4'hf
`define EE_OPC_READ 2'h2
`define EE_OPC_WRITE 2'h1
`define EE_OPC_EXT 2'h0
`define EE_OPC_ERASE 2'h3
`define EE_EXT_LOCK 2'h0
`define EE_EXT_ALL 2'h1
`define EE_EXT_CLEAR_ALL 2'h2
`define EE_EXT_UNLOCK 2'h3
`define EE_ERASED_WORD 16'hffff
`define EE_DUMMY_BIT 1'h0
`define EE_PROG_TIME_MS 10
`define EE_MCLK_KHZ 20000
`define EE_PROG_CNT_W 24

`endif

/* rtl/serial_eeprom_command_port.sv */
// Behaviour
// (RQ1) ignore input until first one sampled after select rises: start bit
// (RQ2) zeros before the start bit are skipped
// (RQ3) read: start, opcode 10, six address bits, then word shifted out
// (RQ4) write: start, opcode 01, address, sixteen data bits msb first
// (RQ5) program-all: opcode 00, field 01xxxx, sixteen data bits
// (RQ6) opcode 00 field 11xxxx unlocks writes, 00xxxx locks them
// (RQ7) erase: opcode 11 plus address; clear-all: opcode 00, field 10xxxx
// (RQ8) writes erase selected cells automatically before storing
// (RQ9) serial input captured on each shift clock rising edge
// (RQ10) read output changes on shift clock rising edges
// (RQ11) dummy zero on last address edge, then sixteen data bits
// (RQ12) continued clocks with select high read following words in turn
// (RQ13) serial output undriven whenever select is low
// (RQ14) host drops select after every command before the next
// (RQ15) reset leaves writes locked until an unlock command
// (RQ16) unlock persists until lock or power loss; reads always work
// (RQ17) programming starts when select falls after the last data bit
// (RQ18) select high during programming shows low busy, high ready
// (RQ19) no command accepted while busy is shown
// (RQ20) programming lasts at most 10 ms; no status once over
// (RQ21) host keeps serial input low while polling status
// (RQ22) select low abandons any partly received command
// (RQ23) program-all stores the word into all 64 locations at once
// (RQ24) host drops select within four clocks of ready
// (RQ25) read words go out most significant bit first
`timescale 1ns/1ps
`include "eeprom_cmd_regs.svh"

module serial_eeprom_command_port
#(
  parameter int unsigned PROG_CYCLES = `EE_PROG_TIME_MS * `EE_MCLK_KHZ
)
(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_select,
  input wire logic i_shift_clock,
  input wire logic i_serial_in,
  output logic o_serial_out,
  output logic o_serial_out_en,
  output logic o_busy
);
  import eeprom_cmd_pkg::*;

  localparam logic [`EE_PROG_CNT_W-1:0] PROG_LOAD =
    PROG_CYCLES[`EE_PROG_CNT_W-1:0];

  logic [`EE_DATA_W-1:0] mem [`EE_DEPTH];

  // two-stage synchronisers; select and shift clock add a third stage for edge finding
  logic [2:0] sel_q;
  logic [2:0] sk_q;
  logic [1:0] di_q;

  seq_state_t state_q, state_d;
  prog_op_t op_q, op_d;
  logic [2:0] cmd_cnt_q, cmd_cnt_d;
  logic [3:0] bit_cnt_q, bit_cnt_d;
  logic [6:0] cmd_q, cmd_d;
  logic [`EE_DATA_W-1:0] shreg_q, shreg_d;
  logic [`EE_ADDR_W-1:0] addr_q, addr_d;
  logic all_q, all_d;
  logic unlock_q, unlock_d;
  logic show_q, show_d;
  logic out_q, out_d;
  logic [`EE_PROG_CNT_W-1:0] prog_cnt_q, prog_cnt_d;

  logic sel;
  logic sel_fall;
  logic sk_rise;
  logic di;
  logic busy;
  logic [7:0] cmd_word;
  logic mem_we;
  logic mem_we_all;
  logic [`EE_DATA_W-1:0] mem_wdata;

  assign sel = sel_q[1];
  assign sel_fall = sel_q[2] & ~sel_q[1];
  assign sk_rise = sk_q[1] & ~sk_q[2];
  assign di = di_q[1];
  assign busy = (prog_cnt_q != '0);
  assign cmd_word = {cmd_q, di};

  always_comb
  begin
    state_d = state_q;
    op_d = op_q;
    cmd_cnt_d = cmd_cnt_q;
    bit_cnt_d = bit_cnt_q;
    cmd_d = cmd_q;
    shreg_d = shreg_q;
    addr_d = addr_q;
    all_d = all_q;
    unlock_d = unlock_q;
    show_d = show_q;
    out_d = out_q;
    prog_cnt_d = prog_cnt_q;
    mem_we = 1'b0;
    mem_we_all = 1'b0;
    mem_wdata = shreg_q;

    // (RQ20) bounded programming timer
    if (busy)
    begin
      prog_cnt_d = prog_cnt_q - 1'b1;
      if (prog_cnt_q == 1)
      begin
        // (RQ8) overwrite is erase then store
        mem_we = (op_q == op_write) || (op_q == op_erase);
        // (RQ23) every word in one cycle
        mem_we_all = (op_q == op_program_all) || (op_q == op_clear_all);
        if ((op_q == op_erase) || (op_q == op_clear_all))
        begin
          mem_wdata = `EE_ERASED_WORD;
        end
        op_d = op_none;
        if (!sel)
        begin
          show_d = 1'b0;
        end
      end
    end

    if (sel_fall)
    begin
      // (RQ22) partial command dropped
      state_d = st_hunt;
      // (RQ17) programming begins on select fall
      if (op_q != op_none && !busy)
      begin
        prog_cnt_d = PROG_LOAD;
        show_d = 1'b1;
      end
      else if (!busy)
      begin
        show_d = 1'b0;
      end
    end
    else if (sel && state_q == st_hunt && show_q)
    begin
      // (RQ18) low while busy, high when ready
      out_d = ~busy;
    end

    // (RQ9) capture on shift clock rise
    if (sel && sk_rise && !sel_fall)
    begin
      case (state_q)
        st_hunt:
        begin
          // (RQ1) first one is the start bit
          // (RQ2) zeros keep hunting
          // (RQ19) nothing taken while busy
          if (di && !busy)
          begin
            state_d = st_cmd;
            cmd_cnt_d = '0;
            show_d = 1'b0;
          end
        end
        st_cmd:
        begin
          cmd_d = cmd_word[6:0];
          cmd_cnt_d = cmd_cnt_q + 1'b1;
          if (cmd_cnt_q == `EE_CMD_LAST)
          begin
            state_d = st_done;
            bit_cnt_d = '0;
            all_d = 1'b0;
            addr_d = cmd_word[5:0];
            case (cmd_word[7:6])
              // (RQ3) read command decoded
              `EE_OPC_READ:
              begin
                // (RQ11) dummy zero on last address edge
                // (RQ16) reads ignore the lock
                out_d = `EE_DUMMY_BIT;
                shreg_d = mem[cmd_word[5:0]];
                state_d = st_read;
              end
              `EE_OPC_WRITE:
              begin
                // (RQ4) sixteen data bits follow
                state_d = st_data;
              end
              `EE_OPC_ERASE:
              begin
                // (RQ7) single word erase
                if (unlock_q)
                begin
                  op_d = op_erase;
                end
              end
              default:
              begin
                case (cmd_word[5:4])
                  // (RQ6) unlock and lock
                  `EE_EXT_UNLOCK: unlock_d = 1'b1;
                  `EE_EXT_LOCK: unlock_d = 1'b0;
                  `EE_EXT_ALL:
                  begin
                    // (RQ5) program-all takes data
                    all_d = 1'b1;
                    state_d = st_data;
                  end
                  default:
                  begin
                    // (RQ7) whole array erase
                    if (unlock_q)
                    begin
                      op_d = op_clear_all;
                    end
                  end
                endcase
              end
            endcase
          end
        end
        st_data:
        begin
          // (RQ4) msb first into shift register
          shreg_d = {shreg_q[`EE_DATA_W-2:0], di};
          bit_cnt_d = bit_cnt_q + 1'b1;
          if (bit_cnt_q == `EE_DATA_LAST)
          begin
            state_d = st_done;
            // (RQ15) locked device refuses writes
            if (unlock_q)
            begin
              op_d = all_q ? op_program_all : op_write;
            end
          end
        end
        st_read:
        begin
          // (RQ10) (RQ25) msb first on each rise
          out_d = shreg_q[`EE_DATA_W-1];
          shreg_d = {shreg_q[`EE_DATA_W-2:0], 1'b0};
          bit_cnt_d = bit_cnt_q + 1'b1;
          if (bit_cnt_q == `EE_DATA_LAST)
          begin
            // (RQ12) next word follows
            addr_d = addr_q + 1'b1;
            shreg_d = mem[addr_q + 1'b1];
          end
        end
        default:
        begin
          state_d = state_q;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      sel_q <= '0;
      sk_q <= '0;
      di_q <= '0;
      state_q <= st_hunt;
      op_q <= op_none;
      cmd_cnt_q <= '0;
      bit_cnt_q <= '0;
      cmd_q <= '0;
      shreg_q <= '0;
      addr_q <= '0;
      all_q <= 1'b0;
      // (RQ15) locked after reset
      unlock_q <= 1'b0;
      show_q <= 1'b0;
      out_q <= 1'b0;
      prog_cnt_q <= '0;
    end
    else
    begin
      sel_q <= {sel_q[1:0], i_select};
      sk_q <= {sk_q[1:0], i_shift_clock};
      di_q <= {di_q[0], i_serial_in};
      state_q <= state_d;
      op_q <= op_d;
      cmd_cnt_q <= cmd_cnt_d;
      bit_cnt_q <= bit_cnt_d;
      cmd_q <= cmd_d;
      shreg_q <= shreg_d;
      addr_q <= addr_d;
      all_q <= all_d;
      unlock_q <= unlock_d;
      show_q <= show_d;
      out_q <= out_d;
      prog_cnt_q <= prog_cnt_d;
    end
  end

  // array has no reset: contents model nonvolatile cells
  genvar gi;
  generate
    for (gi = 0; gi < `EE_DEPTH; gi = gi + 1)
    begin : g_word
      always_ff @(posedge i_mclk)
      begin
        if (mem_we_all || (mem_we && addr_q == gi))
        begin
          mem[gi] <= mem_wdata;
        end
      end
    end
  endgenerate

  assign o_serial_out = out_q;
  // (RQ13) driven only while selected
  assign o_serial_out_en = sel &
    ((state_q == st_read) || (state_q == st_hunt && show_q));
  assign o_busy = busy;

endmodule

/* tb/eeprom_host.sv */
`timescale 1ns/1ps
module eeprom_host
(
  input wire logic i_mclk,
  input wire logic i_serial_out,
  output logic o_select,
  output logic o_shift_clock,
  output logic o_serial_in
);
  initial
  begin
    o_select = 1'b0;
    o_shift_clock = 1'b0;
    o_serial_in = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  // r is what the previous clock rise left on the output
  task automatic bit1(input logic b, output logic r);
    o_select = 1'b1;
    o_serial_in = b;
    tick(4);
    r = i_serial_out;
    o_shift_clock = 1'b1;
    tick(4);
    o_shift_clock = 1'b0;
  endtask
  task automatic cmd(input logic [11:0] c);
    logic r;
    for (int i = 11; i >= 0; i--)
      bit1(c[i], r);
  endtask
  task automatic word(input logic [15:0] d, output logic [15:0] q);
    for (int i = 15; i >= 0; i--)
      bit1(d[i], q[i]);
  endtask
  task automatic desel();
    o_serial_in = 1'b0;
    o_select = 1'b0;
    tick(12);
  endtask
  task automatic poll();
    o_serial_in = 1'b0;
    o_select = 1'b1;
    tick(4);
  endtask
endmodule

/* tb/eeprom_port_chk.sv */
`timescale 1ns/1ps
module eeprom_port_chk
#(
  parameter int unsigned PROG_CYCLES = 50
)
(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_select,
  input wire logic i_shift_clock,
  input wire logic i_serial_in,
  input wire logic o_serial_out,
  input wire logic o_serial_out_en,
  input wire logic o_busy
);
  logic [23:0] cnt_q;
  logic [23:0] cnt_d;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_reset);
  always_comb
  begin
    cnt_d = o_busy ? cnt_q + 24'h1 : 24'h0;
  end
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
      cnt_q <= 24'h0;
    else
      cnt_q <= cnt_d;
  end
  a_hiz_deselect: assert property (!i_select [*5] |-> !o_serial_out_en)
    else $error("output driven while deselected");
  a_en_select: assert property ($rose(o_serial_out_en) |-> $past(i_select, 2))
    else $error("output enabled without select");
  a_busy_start: assert property ($rose(o_busy) |-> !i_select)
    else $error("programming began with select high");
  a_prog_time: assert property ($fell(o_busy) |-> cnt_q == PROG_CYCLES)
    else $error("programming time wrong");
  a_busy_bound: assert property (o_busy |-> cnt_q < PROG_CYCLES)
    else $error("programming overran");
  a_busy_low: assert property (
    o_busy && $past(o_busy) && o_serial_out_en
    && $past(o_serial_out_en) |-> !o_serial_out)
    else $error("busy not shown low");
  a_ready_high: assert property (
    $fell(o_busy) && o_serial_out_en |-> ##[0:2] o_serial_out)
    else $error("ready not shown high");
  // pin rise lands in the output three samples later, via the synchroniser
  a_out_on_rise: assert property (
    o_serial_out_en && $past(o_serial_out_en)
    && !$past(o_busy) && !$past(o_busy, 2) && !$past(o_busy, 3)
    && $changed(o_serial_out) |-> $past(i_shift_clock, 3)
    && !$past(i_shift_clock, 4))
    else $error("output moved without clock rise");
  cover property ($fell(o_busy) && o_serial_out_en);
  cover property ($rose(o_serial_out_en) && !o_busy);
  cover property ($fell(o_busy) && !i_select);
endmodule

bind serial_eeprom_command_port eeprom_port_chk #(.PROG_CYCLES(PROG_CYCLES)) chk
(
  .i_mclk(i_mclk), .i_reset(i_reset), .i_select(i_select),
  .i_shift_clock(i_shift_clock), .i_serial_in(i_serial_in),
  .o_serial_out(o_serial_out), .o_serial_out_en(o_serial_out_en),
  .o_busy(o_busy)
);

/* tb/serial_eeprom_command_port_test.sv */
`timescale 1ns/1ps
module serial_eeprom_command_port_test;
  localparam int unsigned PC = 50;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic sel, sk, di, so, so_en, busy;
  // released pin reads inverted, so a missing enable cannot pass
  logic do_pin;
  assign do_pin = so_en ? so : ~so;
  int errors = 0;
  int cmp_count = 0;
  always #25 i_mclk = ~i_mclk;
  eeprom_host h (.i_mclk(i_mclk), .i_serial_out(do_pin), .o_select(sel),
    .o_shift_clock(sk), .o_serial_in(di));
  serial_eeprom_command_port #(.PROG_CYCLES(PC)) dut (.i_mclk(i_mclk),
    .i_reset(i_reset), .i_select(sel), .i_shift_clock(sk),
    .i_serial_in(di), .o_serial_out(so), .o_serial_out_en(so_en),
    .o_busy(busy));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic prog(input logic [11:0] c, input logic hd,
    input logic [15:0] d, input logic eb);
    logic [15:0] q;
    h.cmd(c);
    if (hd)
      h.word(d, q);
    h.desel();
    check({15'h0, busy}, {15'h0, eb});
    if (eb)
    begin
      h.poll();
      check({14'h0, so_en, so}, 16'h0002);
      repeat (2 * PC) if (busy === 1'b1) @(negedge i_mclk);
      h.tick(4);
      check({14'h0, so_en, so}, 16'h0003);
      h.desel();
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] e0,
    input logic [15:0] e1);
    logic [15:0] q;
    logic r;
    h.cmd({6'h06, a});
    h.bit1(1'b0, r);
    check({15'h0, r}, 16'h0000);
    h.word(16'h0000, q);
    check(q, e0);
    h.word(16'h0000, q);
    check(q, e1);
    h.desel();
  endtask
  task automatic unlock();
    h.cmd({6'h04, 6'h35});
    h.desel();
  endtask
  task automatic t_write();
    prog({6'h05, 6'h05}, 1'b1, 16'h1234, 1'b0);
    unlock();
    prog({6'h05, 6'h3f}, 1'b1, 16'ha5c3, 1'b1);
    prog({6'h05, 6'h00}, 1'b1, 16'h0f0f, 1'b1);
    rd(6'h3f, 16'ha5c3, 16'h0f0f);
  endtask
  task automatic t_all();
    prog({6'h04, 6'h1c}, 1'b1, 16'h3c3c, 1'b1);
    rd(6'h10, 16'h3c3c, 16'h3c3c);
    prog({6'h07, 6'h11}, 1'b0, 16'h0000, 1'b1);
    prog({6'h05, 6'h10}, 1'b1, 16'h00f0, 1'b1);
    rd(6'h10, 16'h00f0, 16'hffff);
    prog({6'h04, 6'h26}, 1'b0, 16'h0000, 1'b1);
    rd(6'h28, 16'hffff, 16'hffff);
  endtask
  task automatic t_lock();
    h.cmd({6'h04, 6'h0a});
    h.desel();
    prog({6'h05, 6'h28}, 1'b1, 16'h1234, 1'b0);
    rd(6'h28, 16'hffff, 16'hffff);
  endtask
  task automatic t_abort();
    logic r;
    unlock();
    h.cmd({6'h05, 6'h08});
    repeat (8) h.bit1(1'b1, r);
    h.desel();
    check({15'h0, busy}, 16'h0000);
  endtask
  task automatic t_reset();
    unlock();
    i_reset = 1'b1;
    repeat (4) @(negedge i_mclk);
    i_reset = 1'b0;
    repeat (4) @(negedge i_mclk);
    prog({6'h05, 6'h28}, 1'b1, 16'h1234, 1'b0);
    rd(6'h28, 16'hffff, 16'hffff);
  endtask
  initial
  begin
    repeat (20) @(negedge i_mclk);
    i_reset = 1'b0;
    repeat (4) @(negedge i_mclk);
    t_write();
    t_all();
    t_lock();
    t_abort();
    t_reset();
    end_of_test();
  end
  // generous bound, the sequence needs about a quarter of it
  initial
  begin
    #1000000;
    errors++;
    end_of_test();
  end
endmodule
